// >>> design/fault_filter.sv
// per-bit fault filter feeding the held fault register
`timescale 1ns/1ps
`default_nettype none
module fault_filter #(
    parameter int W = hb_pkg::FAULT_W,
    parameter int CYCLES = hb_pkg::FAULT_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    fault_if.filter flt
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [W-1:0][CW-1:0] cnt;
        logic [W-1:0] held;
    } filt_state_type;

    filt_state_type st_q;
    filt_state_type st_d;

    // a fault must stand CYCLES clocks before it is held; clear restarts the wait
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < W; i++) begin
            if (flt.clear) begin
                st_d.cnt[i] = '0;
                st_d.held[i] = 1'b0;
            end else if (!flt.raw[i]) begin
                st_d.cnt[i] = '0;
            end else if (!st_q.held[i]) begin
                if (st_q.cnt[i] == LAST) begin
                    st_d.held[i] = 1'b1;
                end else begin
                    st_d.cnt[i] = st_q.cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flt.held = st_q.held;
endmodule : fault_filter
`default_nettype wire

// >>> design/fault_if.sv
// raw fault levels, clear strobe and held fault register between core and filter
`timescale 1ns/1ps
`default_nettype none
interface fault_if #(
    parameter int W = hb_pkg::FAULT_W
);
    logic [W-1:0] raw;
    logic [W-1:0] held;
    logic clear;
    modport filter (input raw, input clear, output held);
    modport core (output raw, output clear, input held);
endinterface : fault_if
`default_nettype wire

// >>> design/half_bridge_spi_frame_control.sv
// serial command and status framing of a triple half-bridge driver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - transfers happen only while chip select low
// - chip select rise latches command if valid
// - serial output released while chip select high
// - frames under sixteen bits are discarded
// - bit counter armed at select fall
// - valid frame clears the fault register
// - standing faults re-latch after filter time
// - status shifts out while command shifts in
// - bit fifteen enables overvoltage output shutoff
// - bit thirteen enables overcurrent driver shutoff
// - bits six to one switch drivers
// - bit zero resets latched status bits
// - status fifteen reports supply fault
// - status fourteen reports underload fault
// - status thirteen reports overload fault
// - drivers off after reset and undervoltage
// - serial accepted once logic supply good and enable high
// - enable low sleeps, high wakes
// - frames shift least significant bit first
// - thermal warning latches until status reset
// - overcurrent shutoff latches until status reset
// - supply fault holds until status reset
module half_bridge_spi_frame_control #(
    parameter int FILTER_CYCLES = hb_pkg::FAULT_FILTER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe_n,
    input wire logic enable,
    input wire logic logic_undervoltage_lockout,
    input wire logic driver_undervoltage_lockout,
    input wire logic supply_overvoltage,
    input wire logic [hb_pkg::DRIVERS-1:0] overcurrent_detect,
    input wire logic [hb_pkg::DRIVERS-1:0] underload_detect,
    input wire logic thermal_warning_detect,
    output logic high_side_1_on,
    output logic low_side_1_on,
    output logic high_side_2_on,
    output logic low_side_2_on,
    output logic high_side_3_on,
    output logic low_side_3_on,
    output logic sleep_active
);
    typedef struct packed {
        logic csb_prev;
        logic sclk_prev;
        logic active;
        logic [hb_pkg::COUNT_W-1:0] bit_count;
        logic [hb_pkg::WORD_W-1:0] shift_in;
        logic [hb_pkg::WORD_W-1:0] shift_out;
        logic [hb_pkg::WORD_W-1:0] command;
        logic so;
        logic so_oe_n;
        logic frame_clear;
        logic supply_fault_flag;
        logic underload_flag;
        logic overload_flag;
        logic thermal_warning_flag;
        logic [hb_pkg::DRIVERS-1:0] latched_off;
        logic [hb_pkg::DRIVERS-1:0] drive;
        logic sleep;
    } core_state_type;

    localparam core_state_type STATE_RESET = '{
        csb_prev: 1'b1,
        so_oe_n: 1'b1,
        command: hb_pkg::COMMAND_RESET,
        default: '0
    };

    // status word as shifted out, unused positions fixed
    function automatic logic [hb_pkg::WORD_W-1:0] status_word(
        input logic supply,
        input logic underload,
        input logic overload,
        input logic thermal,
        input logic [hb_pkg::DRIVERS-1:0] drive
    );
        logic [hb_pkg::WORD_W-1:0] w;
        w = hb_pkg::STATUS_UNUSED_VALUE;
        w[hb_pkg::STS_SUPPLY_FAULT_BIT] = supply;
        w[hb_pkg::STS_UNDERLOAD_BIT] = underload;
        w[hb_pkg::STS_OVERLOAD_BIT] = overload;
        w[hb_pkg::STS_DRIVER_LSB +: hb_pkg::DRIVERS] = drive;
        w[hb_pkg::STS_THERMAL_WARNING_BIT] = thermal;
        return w;
    endfunction : status_word

    hb_pkg::pin_sample_type pin_raw;
    hb_pkg::pin_sample_type pin;
    core_state_type st_q;
    core_state_type st_d;
    logic csb_fall;
    logic csb_rise;
    logic sclk_rise;
    logic serial_ok;
    logic frame_ok;
    logic status_reset;
    logic fault_gate;
    logic driver_block;

    // every pin is asynchronous to sys_clk
    assign pin_raw = '{
        chip_select_n: chip_select_n,
        sclk: serial_clk,
        sdi: serial_data_in,
        enable: enable,
        logic_undervoltage_lockout: logic_undervoltage_lockout,
        driver_undervoltage_lockout: driver_undervoltage_lockout,
        overvoltage: supply_overvoltage,
        thermal: thermal_warning_detect,
        overcurrent: overcurrent_detect,
        underload: underload_detect
    };

    pin_sync #(
        .W($bits(hb_pkg::pin_sample_type)),
        .RESET_VALUE(hb_pkg::PIN_RESET)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .async_in(pin_raw),
        .sync_out(pin)
    );

    fault_if #(.W(hb_pkg::FAULT_W)) fif ();

    // raw fault levels; supply fault covers overvoltage and either undervoltage
    assign fif.raw[hb_pkg::FLT_OVERCURRENT_LSB +: hb_pkg::DRIVERS] = pin.overcurrent;
    assign fif.raw[hb_pkg::FLT_UNDERLOAD] = |pin.underload;
    assign fif.raw[hb_pkg::FLT_SUPPLY] = pin.overvoltage | pin.driver_undervoltage_lockout
        | pin.logic_undervoltage_lockout;
    assign fif.raw[hb_pkg::FLT_THERMAL] = pin.thermal;
    assign fif.clear = st_q.frame_clear;

    fault_filter #(
        .W(hb_pkg::FAULT_W),
        .CYCLES(FILTER_CYCLES)
    ) u_fault_filter (
        .clk(sys_clk),
        .rst_n(rst_n),
        .flt(fif.filter)
    );

    // edges of the sampled serial pins
    assign csb_fall = st_q.csb_prev & ~pin.chip_select_n;
    assign csb_rise = ~st_q.csb_prev & pin.chip_select_n;
    assign sclk_rise = ~st_q.sclk_prev & pin.sclk;
    assign serial_ok = ~pin.logic_undervoltage_lockout & pin.enable;
    // long frames keep the last sixteen bits, so chained devices still latch
    assign frame_ok = csb_rise & st_q.active & serial_ok & ~pin.sclk
        & (st_q.bit_count >= hb_pkg::FRAME_BITS);
    assign status_reset = frame_ok & st_q.shift_in[hb_pkg::CMD_STATUS_RESET_BIT];
    // held faults may not re-set flags while the fault register is being cleared
    assign fault_gate = ~frame_ok & ~st_q.frame_clear;
    assign driver_block = pin.logic_undervoltage_lockout | pin.driver_undervoltage_lockout
        | ~pin.enable
        | (st_q.command[hb_pkg::CMD_OVERVOLTAGE_LOCKOUT_BIT] & pin.overvoltage);

    // frame engine, status flags and driver gating
    always_comb begin
        st_d = st_q;
        st_d.csb_prev = pin.chip_select_n;
        st_d.sclk_prev = pin.sclk;
        st_d.frame_clear = frame_ok;
        if (!serial_ok) begin
            st_d.active = 1'b0;
        end else if (csb_fall) begin
            st_d.active = 1'b1;
            st_d.bit_count = '0;
            // status is ready before the first clock, so bit zero shows at once
            st_d.shift_out = status_word(st_q.supply_fault_flag, st_q.underload_flag,
                st_q.overload_flag, st_q.thermal_warning_flag, st_q.drive);
        end else if (csb_rise) begin
            st_d.active = 1'b0;
        end else if (st_q.active && sclk_rise) begin
            if (st_q.bit_count != hb_pkg::COUNT_MAX) begin
                st_d.bit_count = st_q.bit_count + 1'b1;
            end
            st_d.shift_in = {pin.sdi, st_q.shift_in[hb_pkg::WORD_W-1:1]};
            // input bits follow the status bits out for the next device in a chain
            st_d.shift_out = {pin.sdi, st_q.shift_out[hb_pkg::WORD_W-1:1]};
        end
        if (frame_ok) begin
            st_d.command = st_q.shift_in;
        end
        st_d.so = st_d.shift_out[0];
        st_d.so_oe_n = ~st_d.active;
        // sticky status flags; a status reset clears, held faults set again later
        st_d.supply_fault_flag = (st_q.supply_fault_flag & ~status_reset)
            | (fif.held[hb_pkg::FLT_SUPPLY] & fault_gate);
        st_d.underload_flag = (st_q.underload_flag & ~status_reset)
            | (fif.held[hb_pkg::FLT_UNDERLOAD] & fault_gate);
        st_d.overload_flag = (st_q.overload_flag & ~status_reset)
            | ((|fif.held[hb_pkg::FLT_OVERCURRENT_LSB +: hb_pkg::DRIVERS]) & fault_gate);
        st_d.thermal_warning_flag = (st_q.thermal_warning_flag & ~status_reset)
            | (fif.held[hb_pkg::FLT_THERMAL] & fault_gate);
        // with shutdown disabled an overcurrent is only reported
        for (int i = 0; i < hb_pkg::DRIVERS; i++) begin
            st_d.latched_off[i] = (st_q.latched_off[i] & ~status_reset)
                | (fif.held[hb_pkg::FLT_OVERCURRENT_LSB + i] & fault_gate
                & st_d.command[hb_pkg::CMD_OVERCURRENT_SHUTDOWN_BIT]);
        end
        // command state is kept while blocked, so drivers return when the cause goes
        st_d.drive = st_d.command[hb_pkg::CMD_DRIVER_LSB +: hb_pkg::DRIVERS]
            & ~st_d.latched_off & {hb_pkg::DRIVERS{~driver_block}};
        st_d.sleep = ~pin.enable;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign serial_data_out = st_q.so;
    assign serial_data_out_oe_n = st_q.so_oe_n;
    assign low_side_1_on = st_q.drive[0];
    assign high_side_1_on = st_q.drive[1];
    assign low_side_2_on = st_q.drive[2];
    assign high_side_2_on = st_q.drive[3];
    assign low_side_3_on = st_q.drive[4];
    assign high_side_3_on = st_q.drive[5];
    assign sleep_active = st_q.sleep;

    // checks on the framing and protection behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence frame_end_s;
        frame_ok;
    endsequence

    sequence reset_frame_s;
        frame_ok && st_q.shift_in[hb_pkg::CMD_STATUS_RESET_BIT];
    endsequence

    sequence idle_clock_s;
        pin.chip_select_n && st_q.csb_prev && sclk_rise;
    endsequence

    idle_clock_ignored_a : assert property (idle_clock_s |=> $stable(st_q.shift_in)
        && $stable(st_q.bit_count))
        else $error("serial clock shifted data with chip select high");

    frame_latch_a : assert property (frame_end_s |=> st_q.command == $past(st_q.shift_in))
        else $error("valid frame did not latch the command");

    so_released_a : assert property (pin.chip_select_n && st_q.csb_prev |=> serial_data_out_oe_n)
        else $error("serial output driven while chip select high");

    so_driven_a : assert property (csb_fall && serial_ok |=> !serial_data_out_oe_n
        && serial_data_out == $past(st_q.thermal_warning_flag))
        else $error("serial output not driven with warning bit after select fall");

    short_frame_a : assert property (csb_rise && st_q.bit_count < hb_pkg::FRAME_BITS
        |=> $stable(st_q.command))
        else $error("short frame changed the command");

    counter_arm_a : assert property (csb_fall && serial_ok |=> st_q.bit_count == '0)
        else $error("bit counter not armed at select fall");

    counter_step_a : assert property (st_q.active && sclk_rise && serial_ok && !csb_rise
        && st_q.bit_count != hb_pkg::COUNT_MAX |=> st_q.bit_count == $past(st_q.bit_count) + 1)
        else $error("bit counter did not step on serial clock rise");

    clock_high_end_a : assert property (csb_rise && pin.sclk |=> $stable(st_q.command))
        else $error("frame ending with clock high was latched");

    fault_clear_a : assert property (frame_end_s |=> st_q.frame_clear ##1 fif.held == '0)
        else $error("valid frame did not clear the fault register");

    status_shift_a : assert property (st_q.active && sclk_rise && serial_ok && !csb_rise
        |=> st_q.shift_out == {$past(pin.sdi), $past(st_q.shift_out[hb_pkg::WORD_W-1:1])})
        else $error("status did not shift one bit per clock");

    overvoltage_off_a : assert property (pin.overvoltage
        && st_q.command[hb_pkg::CMD_OVERVOLTAGE_LOCKOUT_BIT] && !frame_ok |=> st_q.drive == '0)
        else $error("drivers on during enabled overvoltage lockout");

    status_reset_a : assert property (reset_frame_s |=> !st_q.thermal_warning_flag [*2]
        ##0 !st_q.supply_fault_flag)
        else $error("status reset did not clear latched flags");

    undervoltage_off_a : assert property (pin.driver_undervoltage_lockout
        || pin.logic_undervoltage_lockout |=> st_q.drive == '0)
        else $error("driver on during undervoltage");

    sleep_off_a : assert property (!pin.enable |=> st_q.drive == '0 && st_q.sleep
        && st_q.so_oe_n)
        else $error("sleep did not stop drivers and serial port");

    overcurrent_latch_a : assert property ((|fif.held[hb_pkg::FLT_OVERCURRENT_LSB +: hb_pkg::DRIVERS])
        && fault_gate && st_q.command[hb_pkg::CMD_OVERCURRENT_SHUTDOWN_BIT] && !status_reset
        |=> (st_q.latched_off & $past(fif.held[hb_pkg::FLT_OVERCURRENT_LSB +: hb_pkg::DRIVERS]))
        == $past(fif.held[hb_pkg::FLT_OVERCURRENT_LSB +: hb_pkg::DRIVERS])
        && (st_q.drive & $past(fif.held[hb_pkg::FLT_OVERCURRENT_LSB +: hb_pkg::DRIVERS])) == '0)
        else $error("overcurrent did not latch driver off");

    // status fields as loaded at select fall, before any clock shifts them
    sequence status_load_s;
        csb_fall && serial_ok;
    endsequence

    status_fields_a : assert property (status_load_s |=> st_q.shift_out[hb_pkg::STS_SUPPLY_FAULT_BIT]
        == $past(st_q.supply_fault_flag)
        && st_q.shift_out[hb_pkg::STS_UNDERLOAD_BIT] == $past(st_q.underload_flag)
        && st_q.shift_out[hb_pkg::STS_OVERLOAD_BIT] == $past(st_q.overload_flag))
        else $error("status fault fields not loaded at select fall");

    driver_status_a : assert property (status_load_s
        |=> st_q.shift_out[hb_pkg::STS_DRIVER_LSB +: hb_pkg::DRIVERS] == $past(st_q.drive))
        else $error("driver states not loaded into status");

    unused_zero_a : assert property (status_load_s
        |=> st_q.shift_out[hb_pkg::STS_OVERLOAD_BIT-1:hb_pkg::STS_DRIVER_LSB+hb_pkg::DRIVERS] == '0)
        else $error("unused status bits not zero");

    short_no_clear_a : assert property (csb_rise && st_q.bit_count < hb_pkg::FRAME_BITS
        |=> !st_q.frame_clear)
        else $error("short frame cleared the fault register");

    lockout_idle_a : assert property (!serial_ok |=> !st_q.active && !st_q.frame_clear)
        else $error("serial port active while asleep or in logic lockout");
endmodule : half_bridge_spi_frame_control
`default_nettype wire

// >>> design/hb_pkg.sv
// shared constants and types of the half-bridge serial command logic
package hb_pkg;
    localparam int WORD_W = 16;
    localparam int COUNT_W = 6;
    localparam int DRIVERS = 6;
    // a frame must carry at least this many clocked bits
    localparam logic [COUNT_W-1:0] FRAME_BITS = 6'h10;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 6'h3F;
    // command word fields
    localparam int CMD_OVERVOLTAGE_LOCKOUT_BIT = 15;
    localparam int CMD_OVERCURRENT_SHUTDOWN_BIT = 13;
    localparam int CMD_DRIVER_LSB = 1;
    localparam int CMD_STATUS_RESET_BIT = 0;
    // status word fields
    localparam int STS_SUPPLY_FAULT_BIT = 15;
    localparam int STS_UNDERLOAD_BIT = 14;
    localparam int STS_OVERLOAD_BIT = 13;
    localparam int STS_DRIVER_LSB = 1;
    localparam int STS_THERMAL_WARNING_BIT = 0;
    localparam logic [WORD_W-1:0] COMMAND_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] STATUS_UNUSED_VALUE = 16'h0000;
    // positions inside the filtered fault vector
    localparam int FLT_OVERCURRENT_LSB = 0;
    localparam int FLT_UNDERLOAD = 6;
    localparam int FLT_SUPPLY = 7;
    localparam int FLT_THERMAL = 8;
    localparam int FAULT_W = 9;
    // fault filter time, a least time, rounded up to whole clocks
    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int FAULT_FILTER_NS = 1000;
    localparam int FAULT_FILTER_CYCLES = (FAULT_FILTER_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // every pin that crosses into the sys_clk domain
    typedef struct packed {
        logic chip_select_n;
        logic sclk;
        logic sdi;
        logic enable;
        logic logic_undervoltage_lockout;
        logic driver_undervoltage_lockout;
        logic overvoltage;
        logic thermal;
        logic [DRIVERS-1:0] overcurrent;
        logic [DRIVERS-1:0] underload;
    } pin_sample_type;
    localparam pin_sample_type PIN_RESET = '{chip_select_n: 1'b1, default: '0};
endpackage : hb_pkg

// >>> design/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_type;

    sync_state_type st_q;
    sync_state_type st_d;

    // meta is read by the second stage only
    always_comb begin
        st_d = st_q;
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{meta: RESET_VALUE, stable: RESET_VALUE};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule : pin_sync
`default_nettype wire

// >>> testbench/spi_host_model.sv
// host serial master model that sends frames and captures the status stream
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic sys_clk,
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe_n
);
    // idle levels follow the pin pulls: select high, clock and data low
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
    end

    // wait n clocks, then step just past the edge
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : ticks

    // one frame of nbits; 4 clocks per clock phase keeps all setup and hold margins
    task automatic frame(input logic [31:0] cmd, input int nbits, output logic [31:0] sts, output logic driven);
        sts = 32'h0000_0000;
        driven = 1'b1;
        ticks(1);
        chip_select_n = 1'b0;
        serial_data_in = cmd[0];
        ticks(4);
        for (int i = 0; i < nbits; i++) begin
            // a released pin has no pull, so the model shows it wrong on purpose
            sts[i] = serial_data_out_oe_n ? ~serial_data_out : serial_data_out;
            driven = driven & ~serial_data_out_oe_n;
            serial_clk = 1'b1;
            ticks(4);
            serial_clk = 1'b0;
            serial_data_in = cmd[i + 1];
            ticks(4);
        end
        // clock already low when select rises
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
        ticks(6);
    endtask : frame

    // stray clocks with select high, then a sixteen-bit frame closed while the clock is high
    task automatic odd_frame(input logic [15:0] cmd);
        for (int i = 0; i < 2; i++) begin
            serial_clk = 1'b1;
            ticks(4);
            serial_clk = 1'b0;
            ticks(4);
        end
        chip_select_n = 1'b0;
        serial_data_in = cmd[0];
        ticks(4);
        for (int i = 0; i < 16; i++) begin
            serial_clk = 1'b1;
            ticks(4);
            if (i < 15) begin
                serial_clk = 1'b0;
                serial_data_in = cmd[i + 1];
                ticks(4);
            end
        end
        // select rises with the clock still high, so the frame must be refused
        chip_select_n = 1'b1;
        ticks(4);
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
        ticks(6);
    endtask : odd_frame
endmodule : spi_host_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the half-bridge serial framing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n;
    logic enable;
    logic lv_lock;
    logic drv_lock;
    logic ov;
    logic thermal;
    logic [5:0] oc;
    logic [5:0] ul;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic sleep_active;
    logic hs1;
    logic ls1;
    logic hs2;
    logic ls2;
    logic hs3;
    logic ls3;
    logic [31:0] sts;
    logic driven;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #20 sys_clk = ~sys_clk;

    spi_host_model host (.sys_clk(sys_clk), .chip_select_n(cs_n), .serial_clk(sclk), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_out_oe_n(sdo_oe_n));

    // short fault filter keeps the relatch waits brief
    half_bridge_spi_frame_control #(.FILTER_CYCLES(2)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .chip_select_n(cs_n), .serial_clk(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
        .serial_data_out_oe_n(sdo_oe_n), .enable(enable), .logic_undervoltage_lockout(lv_lock),
        .driver_undervoltage_lockout(drv_lock), .supply_overvoltage(ov), .overcurrent_detect(oc),
        .underload_detect(ul), .thermal_warning_detect(thermal), .high_side_1_on(hs1), .low_side_1_on(ls1),
        .high_side_2_on(hs2), .low_side_2_on(ls2), .high_side_3_on(hs3), .low_side_3_on(ls3),
        .sleep_active(sleep_active));

    // sleep, output enable, then drivers in command bit order 6 down to 1
    function automatic logic [7:0] pins();
        return {sleep_active, sdo_oe_n, hs3, ls3, hs2, ls2, hs1, ls1};
    endfunction : pins

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t status got %h exp %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_pins(input logic [7:0] exp);
        cmp_count++;
        if (pins() !== exp) begin
            fails++;
            $display("ERROR t=%0t pins got %h exp %h", $time, pins(), exp);
        end
    endtask : check_pins

    // full frame whose returned stream is judged bit by bit
    task automatic rd(input logic [31:0] cmd, input int n, input logic [31:0] exp);
        host.frame(cmd, n, sts, driven);
        check_word(sts & ((32'h1 << n) - 32'h1), exp);
        check_word({31'h0, driven}, 32'h1);
    endtask : rd

    task automatic t_reset();
        check_pins(8'h40);
        $display("test reset done");
    endtask : t_reset

    // each driver alone; the next frame reports the previous state
    task automatic t_drivers();
        logic [31:0] exp;
        exp = 32'h0;
        for (int i = 0; i < 6; i++) begin
            rd(32'h1 << (i + 1), 16, exp);
            check_pins({2'b01, 6'(6'h01 << i)});
            exp = 32'h1 << (i + 1);
        end
        $display("test drivers done");
    endtask : t_drivers

    // short frame dropped, long frame keeps its last sixteen bits
    task automatic t_length();
        host.frame(32'h2, 15, sts, driven);
        check_pins(8'h60);
        rd(32'h0004FF, 24, 32'hFF0040);
        check_pins(8'h42);
        $display("test length done");
    endtask : t_length

    task automatic t_faults();
        ul = 6'h01;
        thermal = 1'b1;
        ov = 1'b1;
        host.ticks(20);
        thermal = 1'b0;
        ov = 1'b0;
        host.ticks(20);
        rd(32'h4, 16, 32'hC005);
        rd(32'h5, 16, 32'hC005);
        host.ticks(20);
        rd(32'h4, 16, 32'h4004);
        ul = 6'h00;
        rd(32'h5, 16, 32'h4004);
        $display("test faults done");
    endtask : t_faults

    task automatic t_overcurrent();
        rd(32'h2004, 16, 32'h0004);
        oc = 6'h02;
        host.ticks(20);
        oc = 6'h00;
        host.ticks(20);
        check_pins(8'h40);
        rd(32'h2005, 16, 32'h2000);
        check_pins(8'h42);
        rd(32'h0004, 16, 32'h0004);
        oc = 6'h02;
        host.ticks(20);
        oc = 6'h00;
        check_pins(8'h42);
        rd(32'h5, 16, 32'h2004);
        $display("test overcurrent done");
    endtask : t_overcurrent

    task automatic t_overvoltage();
        rd(32'h8004, 16, 32'h0004);
        ov = 1'b1;
        host.ticks(10);
        check_pins(8'h40);
        ov = 1'b0;
        host.ticks(10);
        check_pins(8'h42);
        rd(32'h5, 16, 32'h8004);
        ov = 1'b1;
        host.ticks(10);
        check_pins(8'h42);
        ov = 1'b0;
        rd(32'h5, 16, 32'h8004);
        $display("test overvoltage done");
    endtask : t_overvoltage

    // sleep and lockouts: which frames count and which are ignored
    task automatic t_power();
        enable = 1'b0;
        host.ticks(6);
        check_pins(8'hC0);
        host.frame(32'h10, 16, sts, driven);
        check_word({31'h0, driven}, 32'h0);
        enable = 1'b1;
        host.ticks(6);
        check_pins(8'h42);
        drv_lock = 1'b1;
        host.ticks(6);
        check_pins(8'h40);
        host.frame(32'h10, 16, sts, driven);
        check_word({31'h0, driven}, 32'h1);
        check_word(sts, 32'h8000);
        drv_lock = 1'b0;
        host.ticks(6);
        check_pins(8'h48);
        lv_lock = 1'b1;
        host.ticks(6);
        check_pins(8'h40);
        host.frame(32'h4, 16, sts, driven);
        check_word({31'h0, driven}, 32'h0);
        lv_lock = 1'b0;
        host.ticks(6);
        check_pins(8'h48);
        rd(32'h11, 16, 32'h8010);
        $display("test power done");
    endtask : t_power

    // stray clocks with select high and a frame ending with the clock high are both refused
    task automatic t_reject();
        host.odd_frame(16'h0002);
        check_pins(8'h48);
        rd(32'h10, 16, 32'h0010);
        $display("test reject done");
    endtask : t_reject

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        enable = 1'b1;
        lv_lock = 1'b0;
        drv_lock = 1'b0;
        ov = 1'b0;
        thermal = 1'b0;
        oc = 6'h00;
        ul = 6'h00;
        host.ticks(2);
        rst_n = 1'b1;
        host.ticks(3);
        t_reset();
        t_drivers();
        t_length();
        t_faults();
        t_overcurrent();
        t_overvoltage();
        t_power();
        t_reject();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
